// *** rtl/dcc_top.sv ***
// Converter channel control: config, reference steering and held output codes
// Assumes a classic Wishbone master and a separate power-on reset input
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns

module dcc_top (
    // Clock and resets
    input  wire logic                                   clk,
    input  wire logic                                   reset,
    input  wire logic                                   por,
    // Wishbone slave
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [dcc_pkg::ADR_W-1:0]              wb_adr_i,
    input  wire logic [3:0]                             wb_sel_i,
    input  wire logic [dcc_pkg::DATA_W-1:0]             wb_dat_i,
    output logic [dcc_pkg::DATA_W-1:0]                  wb_dat_o,
    output logic                                        wb_ack_o,
    // Channel codes
    output logic [dcc_pkg::CH_N-1:0][dcc_pkg::CODE_W-1:0] channel_code,
    // Channel control
    output logic [dcc_pkg::CH_N-1:0]                    channel_enable,
    output logic [dcc_pkg::CH_N-1:0]                    channel_power_down,
    output logic [dcc_pkg::CH_N-1:0]                    channel_int_ref,
    output logic [dcc_pkg::CH_N-1:0]                    channel_ext_ref,
    // References and pins
    output logic                                        int_ref_power_up,
    output logic                                        ext_ref_pin_a,
    output logic                                        ext_ref_pin_b,
    output logic                                        ref_a_analog_enable,
    output logic                                        ref_b_analog_enable
);

    // ============================================================
    // Declarations
    localparam int CH_N   = dcc_pkg::CH_N;
    localparam int GRP    = dcc_pkg::GROUP_N;
    localparam int FW     = dcc_pkg::FIELD_W;
    localparam int CW     = dcc_pkg::CODE_W;
    localparam int RW     = dcc_pkg::REG_W;

    logic                       soft_reset;
    logic                       wr_take;
    logic [RW-1:0]              rd_data;
    logic [RW-1:0]              wr_word;
    logic [1:0]                 wr_sel;

    logic                       cfg_hit;
    logic                       ref_hit;
    logic                       stat_hit;
    logic [CH_N-1:0]            code_hit;

    logic [RW-1:0]              config_q;
    logic [RW-1:0]              config_d;
    logic [1:0]                 ref_pin_q;
    logic [1:0]                 ref_pin_d;
    logic [CH_N-1:0][CW-1:0]    code_q;
    logic [CH_N-1:0][CW-1:0]    code_d;

    logic [CH_N-1:0]            sel_off;
    logic [CH_N-1:0]            sel_ext;
    logic [CH_N-1:0]            sel_int;
    logic [CH_N-1:0]            sel_rsvd;
    logic                       int_any;
    logic                       a_any;
    logic                       b_any;

    logic [CH_N-1:0]            enable_q;
    logic [CH_N-1:0]            enable_d;
    logic [CH_N-1:0]            pdown_q;
    logic [CH_N-1:0]            pdown_d;
    logic [CH_N-1:0]            int_sel_q;
    logic [CH_N-1:0]            int_sel_d;
    logic [CH_N-1:0]            ext_sel_q;
    logic [CH_N-1:0]            ext_sel_d;
    logic [CH_N-1:0]            rsvd_q;
    logic [CH_N-1:0]            rsvd_d;
    logic                       int_up_q;
    logic                       int_up_d;
    logic                       pin_a_q;
    logic                       pin_a_d;
    logic                       pin_b_q;
    logic                       pin_b_d;
    logic                       a_unready_q;
    logic                       a_unready_d;
    logic                       b_unready_q;
    logic                       b_unready_d;
    logic [RW-1:0]              status_word;

    // Power-on also resets everything that plain reset does
    assign soft_reset = reset || por;
    assign wr_word    = wb_dat_i[RW-1:0];
    assign wr_sel     = wb_sel_i[1:0];

    // ============================================================
    // Bus handshake
    dcc_wb_slave u_bus (
        .clk      (clk),
        .reset    (soft_reset),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .rd_data  (rd_data),
        .wr_take  (wr_take),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o)
    );

    // ============================================================
    // Address decode
    assign cfg_hit  = (wb_adr_i == dcc_pkg::OFF_CONFIG);
    assign ref_hit  = (wb_adr_i == dcc_pkg::OFF_REF_PIN);
    assign stat_hit = (wb_adr_i == dcc_pkg::OFF_STATUS);

    // ============================================================
    // Shared configuration register
    always_comb begin
        config_d = config_q;
        if (wr_take && cfg_hit) begin
            config_d = dcc_pkg::merge16(config_q, wr_word, wr_sel);
        end
    end

    always_ff @(posedge clk) begin
        if (soft_reset) begin
            config_q <= dcc_pkg::CONFIG_RST;
        end else begin
            config_q <= config_d;
        end
    end

    // ============================================================
    // Reference-pin configuration register
    always_comb begin
        ref_pin_d = ref_pin_q;
        if (wr_take && ref_hit && wr_sel[0]) begin
            ref_pin_d[dcc_pkg::REF_A_BIT] = wr_word[dcc_pkg::REF_A_BIT];
            ref_pin_d[dcc_pkg::REF_B_BIT] = wr_word[dcc_pkg::REF_B_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (soft_reset) begin
            ref_pin_q <= dcc_pkg::REF_PIN_RST;
        end else begin
            ref_pin_q <= ref_pin_d;
        end
    end

    // ============================================================
    // Per-channel code registers and field decode
    genvar i;
    generate
        for (i = 0; i < CH_N; i = i + 1) begin : g_ch
            localparam logic [dcc_pkg::ADR_W-1:0] CODE_ADR =
                dcc_pkg::OFF_CODE_BASE + 8'(i) * dcc_pkg::CODE_STRIDE;
            logic [RW-1:0]  merged;
            logic [FW-1:0]  field;

            assign code_hit[i] = (wb_adr_i == CODE_ADR);
            assign merged = dcc_pkg::merge16({4'h0, code_q[i]}, wr_word, wr_sel);

            // Reserved top bits are dropped on write
            always_comb begin
                code_d[i] = code_q[i];
                if (wr_take && code_hit[i]) begin
                    code_d[i] = merged[CW-1:0];
                end
            end

            // Only power-on clears a code
            always_ff @(posedge clk) begin
                if (por) begin
                    code_q[i] <= dcc_pkg::CODE_RST;
                end else begin
                    code_q[i] <= code_d[i];
                end
            end

            // Field decode for this channel
            assign field       = config_q[FW*i +: FW];
            assign sel_off[i]  = (field == dcc_pkg::REF_OFF);
            assign sel_ext[i]  = (field == dcc_pkg::REF_EXT);
            assign sel_int[i]  = (field == dcc_pkg::REF_INT);
            assign sel_rsvd[i] = (field == dcc_pkg::REF_RSVD);
        end
    endgenerate

    // ============================================================
    // Group reductions
    assign int_any = |sel_int;
    assign a_any   = |sel_ext[GRP-1:0];
    assign b_any   = |sel_ext[CH_N-1:GRP];

    // ============================================================
    // Registered channel and reference controls
    always_comb begin
        enable_d    = sel_ext | sel_int;
        pdown_d     = sel_off | sel_rsvd;
        int_sel_d   = sel_int;
        ext_sel_d   = sel_ext;
        rsvd_d      = sel_rsvd;
        int_up_d    = int_any;
        pin_a_d     = a_any;
        pin_b_d     = b_any;
        a_unready_d = a_any && !ref_pin_q[dcc_pkg::REF_A_BIT];
        b_unready_d = b_any && !ref_pin_q[dcc_pkg::REF_B_BIT];
    end

    always_ff @(posedge clk) begin
        if (soft_reset) begin
            enable_q    <= 8'h00;
            pdown_q     <= 8'hff;
            int_sel_q   <= 8'h00;
            ext_sel_q   <= 8'h00;
            rsvd_q      <= 8'h00;
            int_up_q    <= 1'b0;
            pin_a_q     <= 1'b0;
            pin_b_q     <= 1'b0;
            a_unready_q <= 1'b0;
            b_unready_q <= 1'b0;
        end else begin
            enable_q    <= enable_d;
            pdown_q     <= pdown_d;
            int_sel_q   <= int_sel_d;
            ext_sel_q   <= ext_sel_d;
            rsvd_q      <= rsvd_d;
            int_up_q    <= int_up_d;
            pin_a_q     <= pin_a_d;
            pin_b_q     <= pin_b_d;
            a_unready_q <= a_unready_d;
            b_unready_q <= b_unready_d;
        end
    end

    // ============================================================
    // Status word
    always_comb begin
        status_word = 16'h0000;
        status_word[dcc_pkg::ST_INT_REF]   = int_up_q;
        status_word[dcc_pkg::ST_PIN_A]     = pin_a_q;
        status_word[dcc_pkg::ST_PIN_B]     = pin_b_q;
        status_word[dcc_pkg::ST_A_UNREADY] = a_unready_q;
        status_word[dcc_pkg::ST_B_UNREADY] = b_unready_q;
        status_word[dcc_pkg::ST_RSVD_LSB +: CH_N] = rsvd_q;
    end

    // ============================================================
    // Read mux
    always_comb begin
        rd_data = 16'h0000;
        if (cfg_hit) begin
            rd_data = config_q;
        end else if (ref_hit) begin
            rd_data = {14'h0000, ref_pin_q};
        end else if (stat_hit) begin
            rd_data = status_word;
        end else begin
            for (int k = 0; k < CH_N; k++) begin
                if (code_hit[k]) begin
                    rd_data = {4'h0, code_q[k]};
                end
            end
        end
    end

    // ============================================================
    // Outputs
    assign channel_code        = code_q;
    assign channel_enable      = enable_q;
    assign channel_power_down  = pdown_q;
    assign channel_int_ref     = int_sel_q;
    assign channel_ext_ref     = ext_sel_q;
    assign int_ref_power_up    = int_up_q;
    assign ext_ref_pin_a       = pin_a_q;
    assign ext_ref_pin_b       = pin_b_q;
    assign ref_a_analog_enable = ref_pin_q[dcc_pkg::REF_A_BIT];
    assign ref_b_analog_enable = ref_pin_q[dcc_pkg::REF_B_BIT];

endmodule

// *** rtl/dcc_pkg.sv ***
// Constants, field layouts and register map of the converter channel control
// Assumes a classic Wishbone slave with 32-bit data and byte addresses

package dcc_pkg;

    // ============================================================
    // Widths
    localparam int CH_N     = 8;
    localparam int GROUP_N  = 4;
    localparam int CODE_W   = 12;
    localparam int FIELD_W  = 2;
    localparam int REG_W    = 16;
    localparam int DATA_W   = 32;
    localparam int ADR_W    = 8;

    // ============================================================
    // Register byte offsets
    localparam logic [ADR_W-1:0] OFF_CONFIG    = 8'h00;
    localparam logic [ADR_W-1:0] OFF_REF_PIN   = 8'h04;
    localparam logic [ADR_W-1:0] OFF_STATUS    = 8'h08;
    localparam logic [ADR_W-1:0] OFF_CODE_BASE = 8'h20;
    localparam logic [ADR_W-1:0] CODE_STRIDE   = 8'h04;

    // ============================================================
    // Field encodings
    localparam logic [FIELD_W-1:0] REF_OFF  = 2'h0;
    localparam logic [FIELD_W-1:0] REF_EXT  = 2'h1;
    localparam logic [FIELD_W-1:0] REF_INT  = 2'h2;
    localparam logic [FIELD_W-1:0] REF_RSVD = 2'h3;

    // ============================================================
    // Reset values
    localparam logic [REG_W-1:0]  CONFIG_RST  = 16'h0000;
    localparam logic [1:0]        REF_PIN_RST = 2'h0;
    localparam logic [CODE_W-1:0] CODE_RST    = 12'h000;

    // ============================================================
    // Bit positions
    localparam int REF_A_BIT     = 0;
    localparam int REF_B_BIT     = 1;
    localparam int ST_INT_REF    = 0;
    localparam int ST_PIN_A      = 1;
    localparam int ST_PIN_B      = 2;
    localparam int ST_A_UNREADY  = 3;
    localparam int ST_B_UNREADY  = 4;
    localparam int ST_RSVD_LSB   = 8;

    // ============================================================
    // Bus slave states
    typedef enum logic {
        DCC_BUS_IDLE,
        DCC_BUS_ACK
    } dcc_bus_state_t;

    // Byte-lane merge of a 16-bit register
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0] old_v,
        input logic [REG_W-1:0] new_v,
        input logic [1:0]       sel
    );
        logic [REG_W-1:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

endpackage

// *** rtl/dcc_wb_slave.sv ***
// Classic Wishbone handshake for the converter channel control
// Assumes the parent decodes the address and supplies read data combinationally
`timescale 1ns/1ns

module dcc_wb_slave (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Bus requests
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    // Register file side
    input  wire logic [dcc_pkg::REG_W-1:0]  rd_data,
    output logic                            wr_take,
    // Bus answers
    output logic [dcc_pkg::DATA_W-1:0]      wb_dat_o,
    output logic                            wb_ack_o
);

    // ============================================================
    // Handshake state
    dcc_pkg::dcc_bus_state_t            state_q;
    dcc_pkg::dcc_bus_state_t            state_d;
    logic [dcc_pkg::DATA_W-1:0]         dat_q;
    logic [dcc_pkg::DATA_W-1:0]         dat_d;
    logic                               take;

    assign take     = wb_cyc_i && wb_stb_i && (state_q == dcc_pkg::DCC_BUS_IDLE);
    assign wr_take  = take && wb_we_i;
    assign wb_ack_o = (state_q == dcc_pkg::DCC_BUS_ACK);
    assign wb_dat_o = dat_q;

    always_comb begin
        state_d = state_q;
        dat_d   = dat_q;
        case (state_q)
            dcc_pkg::DCC_BUS_IDLE: begin
                if (take) begin
                    state_d = dcc_pkg::DCC_BUS_ACK;
                    dat_d   = wb_we_i ? 32'h0000_0000 : {16'h0000, rd_data};
                end
            end
            dcc_pkg::DCC_BUS_ACK: begin
                state_d = dcc_pkg::DCC_BUS_IDLE;
            end
            default: begin
                state_d = dcc_pkg::DCC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= dcc_pkg::DCC_BUS_IDLE;
            dat_q   <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            dat_q   <= dat_d;
        end
    end

endmodule

// *** verif/dcc_assertions.sv ***
// Concurrent checks on the converter channel control top-level ports
// Assumes binding to dcc_top; one clock, reset and por both synchronous
`timescale 1ns/1ns

module dcc_checker (
    // Clock and resets
    input wire logic                                        clk,
    input wire logic                                        reset,
    input wire logic                                        por,
    // Bus
    input wire logic                                        wb_cyc_i,
    input wire logic                                        wb_stb_i,
    input wire logic                                        wb_we_i,
    input wire logic [dcc_pkg::ADR_W-1:0]                   wb_adr_i,
    input wire logic [3:0]                                  wb_sel_i,
    input wire logic [dcc_pkg::DATA_W-1:0]                  wb_dat_i,
    input wire logic                                        wb_ack_o,
    // Channels and references
    input wire logic [dcc_pkg::CH_N-1:0][dcc_pkg::CODE_W-1:0] channel_code,
    input wire logic [dcc_pkg::CH_N-1:0]                    channel_enable,
    input wire logic [dcc_pkg::CH_N-1:0]                    channel_power_down,
    input wire logic [dcc_pkg::CH_N-1:0]                    channel_int_ref,
    input wire logic [dcc_pkg::CH_N-1:0]                    channel_ext_ref,
    input wire logic                                        int_ref_power_up,
    input wire logic                                        ext_ref_pin_a,
    input wire logic                                        ext_ref_pin_b,
    input wire logic                                        ref_a_analog_enable,
    input wire logic                                        ref_b_analog_enable
);
    // ============================================================
    // Code register write taken
    logic code_wr;
    assign code_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                     && (wb_adr_i[7:5] == 3'b001) && (wb_adr_i[1:0] == 2'b00);

    // ============================================================
    // Assertions
    a_ack_answer: assert property (@(posedge clk) disable iff (reset || por)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (@(posedge clk) disable iff (reset || por)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_enable_ref: assert property (@(posedge clk) disable iff (reset || por)
        (channel_enable == (channel_int_ref | channel_ext_ref))
        && ((channel_int_ref & channel_ext_ref) == 8'h00)) else $error("enable mismatch");
    a_power_down: assert property (@(posedge clk) disable iff (reset || por)
        channel_power_down == ~channel_enable) else $error("power down mismatch");
    a_int_ref_up: assert property (@(posedge clk) disable iff (reset || por)
        int_ref_power_up == (|channel_int_ref)) else $error("internal ref power wrong");
    a_pin_a_func: assert property (@(posedge clk) disable iff (reset || por)
        ext_ref_pin_a == (|channel_ext_ref[3:0])) else $error("pin A function wrong");
    a_pin_b_func: assert property (@(posedge clk) disable iff (reset || por)
        ext_ref_pin_b == (|channel_ext_ref[7:4])) else $error("pin B function wrong");
    a_code_write: assert property (@(posedge clk) disable iff (reset || por)
        (code_wr && wb_sel_i[1:0] == 2'b11)
        |=> channel_code[wb_adr_i[4:2]] == wb_dat_i[11:0]) else $error("code not updated");
    a_code_hold: assert property (@(posedge clk) disable iff (por)
        !code_wr |=> $stable(channel_code)) else $error("code changed without write");
    a_reset_state: assert property (@(posedge clk) disable iff (por)
        reset |=> (channel_enable == 8'h00) && (channel_power_down == 8'hFF)
        && !int_ref_power_up && !ext_ref_pin_a && !ext_ref_pin_b
        && !ref_a_analog_enable && !ref_b_analog_enable) else $error("reset state wrong");

    // ============================================================
    // Covers
    c_code_wr: cover property (@(posedge clk) disable iff (reset || por) code_wr);
    c_int_up: cover property (@(posedge clk) disable iff (reset || por) $rose(int_ref_power_up));
    c_both_pins: cover property (@(posedge clk) disable iff (reset || por)
        ext_ref_pin_a && ext_ref_pin_b);
endmodule

bind dcc_top dcc_checker u_chk (
    .clk(clk), .reset(reset), .por(por), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .channel_code(channel_code), .channel_enable(channel_enable),
    .channel_power_down(channel_power_down), .channel_int_ref(channel_int_ref),
    .channel_ext_ref(channel_ext_ref), .int_ref_power_up(int_ref_power_up),
    .ext_ref_pin_a(ext_ref_pin_a), .ext_ref_pin_b(ext_ref_pin_b),
    .ref_a_analog_enable(ref_a_analog_enable), .ref_b_analog_enable(ref_b_analog_enable)
);

// *** verif/dcc_top_bench.sv ***
// Self-checking bench for the converter channel control top
// Assumes the bound checker and a classic Wishbone master driven from here
`timescale 1ns/1ns

module dcc_top_bench;
    typedef struct {
        logic [15:0] cfg;
        logic [7:0]  en;
        logic [7:0]  pd;
        logic [7:0]  ir;
        logic [7:0]  er;
        logic [2:0]  fl;
    } dcc_row_t;

    logic                                          clk;
    logic                                          reset;
    logic                                          por;
    logic                                          wb_cyc_i;
    logic                                          wb_stb_i;
    logic                                          wb_we_i;
    logic [dcc_pkg::ADR_W-1:0]                     wb_adr_i;
    logic [3:0]                                    wb_sel_i;
    logic [dcc_pkg::DATA_W-1:0]                    wb_dat_i;
    logic [dcc_pkg::DATA_W-1:0]                    wb_dat_o;
    logic                                          wb_ack_o;
    logic [dcc_pkg::CH_N-1:0][dcc_pkg::CODE_W-1:0] channel_code;
    logic [dcc_pkg::CH_N-1:0]                      channel_enable;
    logic [dcc_pkg::CH_N-1:0]                      channel_power_down;
    logic [dcc_pkg::CH_N-1:0]                      channel_int_ref;
    logic [dcc_pkg::CH_N-1:0]                      channel_ext_ref;
    logic                                          int_ref_power_up;
    logic                                          ext_ref_pin_a;
    logic                                          ext_ref_pin_b;
    logic                                          ref_a_analog_enable;
    logic                                          ref_b_analog_enable;
    int                                            miscompares;
    int                                            tests_run;
    logic [15:0]                                   codes [8];
    logic [31:0]                                   rd;
    dcc_row_t                                      rows [7];

    dcc_top DUT (
        .clk(clk), .reset(reset), .por(por), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_code(channel_code),
        .channel_enable(channel_enable), .channel_power_down(channel_power_down),
        .channel_int_ref(channel_int_ref), .channel_ext_ref(channel_ext_ref),
        .int_ref_power_up(int_ref_power_up), .ext_ref_pin_a(ext_ref_pin_a),
        .ext_ref_pin_b(ext_ref_pin_b), .ref_a_analog_enable(ref_a_analog_enable),
        .ref_b_analog_enable(ref_b_analog_enable)
    );

    // ============================================================
    // Clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // ============================================================
    // Tasks
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, s, q);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask

    task automatic pulse(input logic p);
        @(posedge clk);
        {por, reset} <= p ? 2'b10 : 2'b01;
        repeat (3) @(posedge clk);
        {por, reset} <= 2'b00;
        @(negedge clk);
    endtask

    function automatic logic [7:0] code_adr(input int ch);
        return 8'(dcc_pkg::OFF_CODE_BASE + ch * dcc_pkg::CODE_STRIDE);
    endfunction

    // ============================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    // ============================================================
    // Main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        reset = 1'b1;
        por = 1'b1;
        miscompares = 0;
        tests_run = 0;
        rows[0] = '{16'h0002, 8'h01, 8'hFE, 8'h01, 8'h00, 3'b100};
        rows[1] = '{16'h0010, 8'h04, 8'hFB, 8'h00, 8'h04, 3'b010};
        rows[2] = '{16'h1000, 8'h40, 8'hBF, 8'h00, 8'h40, 3'b001};
        rows[3] = '{16'h5555, 8'hFF, 8'h00, 8'h00, 8'hFF, 3'b011};
        rows[4] = '{16'hAAAA, 8'hFF, 8'h00, 8'hFF, 8'h00, 3'b100};
        rows[5] = '{16'h4080, 8'h88, 8'h77, 8'h08, 8'h80, 3'b101};
        rows[6] = '{16'h0000, 8'h00, 8'hFF, 8'h00, 8'h00, 3'b000};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        por   <= 1'b0;
        @(negedge clk);
        cmp({channel_enable, channel_power_down}, 32'h0000_00FF);
        cmp({int_ref_power_up, ext_ref_pin_a, ext_ref_pin_b}, 32'h0);
        rd_reg(dcc_pkg::OFF_CONFIG, rd);
        cmp(rd, 32'h0000_0000);
        rd_reg(dcc_pkg::OFF_REF_PIN, rd);
        cmp(rd, 32'h0000_0000);
        rd_reg(code_adr(5), rd);
        cmp(rd, 32'h0000_0000);
        wr(dcc_pkg::OFF_REF_PIN, 32'hFFFF_FFFF, 4'hF);
        rd_reg(dcc_pkg::OFF_REF_PIN, rd);
        cmp(rd, 32'h0000_0003);
        cmp({ref_b_analog_enable, ref_a_analog_enable}, 32'h3);
        foreach (rows[i]) begin
            wr(dcc_pkg::OFF_CONFIG, {16'h0000, rows[i].cfg}, 4'hF);
            @(negedge clk);
            cmp(channel_enable, rows[i].en);
            cmp(channel_power_down, rows[i].pd);
            cmp({channel_int_ref, channel_ext_ref}, {rows[i].ir, rows[i].er});
            cmp({int_ref_power_up, ext_ref_pin_a, ext_ref_pin_b}, rows[i].fl);
            rd_reg(dcc_pkg::OFF_CONFIG, rd);
            cmp(rd, {16'h0000, rows[i].cfg});
        end
        for (int ch = 0; ch < 8; ch++) begin
            codes[ch] = 16'h00A5 + 16'(ch) * 16'h0111;
            wr(code_adr(ch), {16'h0000, 16'hF000 | codes[ch]}, 4'hF);
            cmp(channel_code[ch], codes[ch]);
            rd_reg(code_adr(ch), rd);
            cmp(rd, codes[ch]);
        end
        wr(dcc_pkg::OFF_CONFIG, 32'h0000_5555, 4'hF);
        wr(dcc_pkg::OFF_CONFIG, 32'h0000_AAAA, 4'b0001);
        rd_reg(dcc_pkg::OFF_CONFIG, rd);
        cmp(rd, 32'h0000_55AA);
        cmp({int_ref_power_up, ext_ref_pin_a, ext_ref_pin_b}, 32'h5);
        wr(8'h80, 32'h0000_1234, 4'hF);
        rd_reg(8'h80, rd);
        cmp(rd, 32'h0000_0000);
        rd_reg(dcc_pkg::OFF_CONFIG, rd);
        cmp(rd, 32'h0000_55AA);
        pulse(1'b0);
        cmp({channel_enable, channel_power_down}, 32'h0000_00FF);
        cmp({int_ref_power_up, ext_ref_pin_a, ext_ref_pin_b}, 32'h0);
        cmp({ref_b_analog_enable, ref_a_analog_enable}, 32'h0);
        for (int ch = 0; ch < 8; ch++) begin
            cmp(channel_code[ch], codes[ch]);
        end
        rd_reg(dcc_pkg::OFF_CONFIG, rd);
        cmp(rd, 32'h0000_0000);
        wr(dcc_pkg::OFF_REF_PIN, 32'h0000_0001, 4'hF);
        @(negedge clk);
        cmp({ref_b_analog_enable, ref_a_analog_enable}, 32'h1);
        wr(dcc_pkg::OFF_CONFIG, 32'h0000_1000, 4'hF);
        rd_reg(dcc_pkg::OFF_STATUS, rd);
        cmp(rd, 32'h0000_0014);
        pulse(1'b1);
        for (int ch = 0; ch < 8; ch++) begin
            cmp(channel_code[ch], 32'h0);
        end
        rd_reg(code_adr(3), rd);
        cmp(rd, 32'h0000_0000);
        print_verdict();
    end
endmodule
